// *** hdl/fmnt_gateware_top.sv ***
// top of the fieldbus master node: clock, reset, queues, irq, dac
`timescale 1ns/1ps
// Overview of operation
// [R1] every unit runs on one 100 MHz domain
// [R2] 100 MHz derived from 125 MHz carrier clock
// [R3] host reset synchronised before distribution
// [R4] two processors share a dedicated memory
// [R5] eight outgoing, two incoming host queues
// [R6] no remote queues, no timing network
// [R7] wrapper talks to application core over bus
// [R8] first incoming queue: startup config to player
// [R9] second incoming queue: runtime requests to poller
// [R10] outgoing queues have fixed roles
// [R11] player checks stop/reset at window end
// [R12] poller forwards payloads and stop/reset
// [R13] all interrupts merge onto one line
// [R14] bridge raises interrupt on rising edge
// [R15] every queue push raises an interrupt; a push during a pulse only extends it, with no new edge
// [R16] region 0 local bus, region 4 bridge
// [R17] DAC receives fixed code 0x9999
// [R18] DAC written once after reset, then idle
// [R19] interrupt pulse lasts at least one cycle
module fmnt_gateware_top
   import fmnt_pkg::*;
(
   // carrier clock and host reset
   input  wire logic                      mclk_i,
   input  wire logic                      arst_n_i,
   // host bridge access
   input  wire logic                      host_req_i,
   input  wire logic [2:0]                host_bar_i,
   // queue push strobes
   input  wire logic [NUM_OUT_QUEUES-1:0] out_push_i,
   input  wire logic [NUM_IN_QUEUES-1:0]  in_push_i,
   input  wire logic [3:0]                in_cmd_i,
   // end of a cycle window
   input  wire logic                      window_end_i,
   // system clock enable and synchronised reset
   output logic                           sys_ce_o,
   output logic                           sys_rst_n_o,
   // host bridge routing
   output logic                           local_bus_sel_o,
   output logic                           bridge_reg_sel_o,
   output logic                           dma_port_used_o,
   // routed incoming commands
   output logic                           player_cmd_valid_o,
   output logic                           poller_cmd_valid_o,
   // stop/reset seen by the player
   output logic                           player_stop_o,
   output logic                           player_reset_o,
   // merged interrupt to bridge GPIO
   output logic                           irq_o,
   // oscillator DAC serial lines
   output logic                           dac_sclk_o,
   output logic                           dac_sync_n_o,
   output logic                           dac_din_o,
   output logic                           dac_done_o
);
   // divider, enable and synchronised reset
   logic [2:0]                 div_cnt;
   logic                       ce;
   logic [RST_SYNC_STAGES-1:0] rst_sync;
   logic                       srst_n;
   // stop and reset mailbox kept for the player
   logic                       pend_stop;
   logic                       pend_reset;
   // interrupt sources and pulse timer
   logic                       player_push;
   logic                       poller_push;
   logic                       shared_push;
   logic                       irq_any;
   logic [3:0]                 irq_cnt;
   // serial lines from the DAC arbiter
   fmnt_dac_if                 dac_bus ();

   // =========================================================
   // decode helpers, each used twice below
   // host access aimed at one region
   function automatic logic region_hit(input logic       req,
                                       input logic [2:0] bar,
                                       input logic [2:0] region);
      region_hit = req && (bar == region);
   endfunction

   // runtime queue push carrying one command code
   function automatic logic runtime_hit(input logic [1:0] push,
                                        input logic [3:0] cmd,
                                        input fmnt_cmd_t  code);
      runtime_hit = push[IQ_RUNTIME] && (cmd == code);
   endfunction

   // =========================================================
   // fractional divide 125 to 100 MHz as a clock enable
   // a true PLL would be used on silicon; an enable keeps one clock net
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_cnt <= 3'h0;
      end else if (div_cnt == CLK_DIV_PERIOD - 3'h1) begin
         div_cnt <= 3'h0; // [R2]
      end else begin
         div_cnt <= div_cnt + 3'h1;
      end
   end

   // drop one carrier cycle in five
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ce <= 1'b0;
      end else begin
         ce <= (div_cnt != CLK_DIV_SKIP); // [R1]
      end
   end

   // =========================================================
   // host reset synchroniser; release only on the enable
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync <= '0;
      end else if (ce) begin
         rst_sync <= {rst_sync[RST_SYNC_STAGES-2:0], 1'b1}; // [R3]
      end
   end
   assign srst_n = rst_sync[RST_SYNC_STAGES-1];

   // registered copies of enable and reset
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sys_ce_o    <= 1'b0;
         sys_rst_n_o <= 1'b0;
      end else begin
         sys_ce_o    <= ce;
         sys_rst_n_o <= srst_n;
      end
   end

   // =========================================================
   // host region decode; the DMA port is never used
   // requests on skipped cycles are ignored, so the host holds them
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         local_bus_sel_o  <= 1'b0;
         bridge_reg_sel_o <= 1'b0;
         dma_port_used_o  <= 1'b0;
      end else if (!srst_n) begin
         local_bus_sel_o  <= 1'b0;
         bridge_reg_sel_o <= 1'b0;
      end else if (ce) begin
         if (region_hit(host_req_i, host_bar_i, BAR_LOCAL_BUS)) begin
            local_bus_sel_o  <= 1'b1; // [R16]
            bridge_reg_sel_o <= 1'b0;
         end else if (region_hit(host_req_i, host_bar_i, BAR_BRIDGE)) begin
            local_bus_sel_o  <= 1'b0;
            bridge_reg_sel_o <= 1'b1; // [R16]
         end else begin
            local_bus_sel_o  <= 1'b0;
            bridge_reg_sel_o <= 1'b0;
         end
      end
   end

   // =========================================================
   // incoming queue routing: config to player, runtime to poller
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         player_cmd_valid_o <= 1'b0;
      end else if (!srst_n) begin
         player_cmd_valid_o <= 1'b0;
      end else if (ce) begin
         player_cmd_valid_o <= in_push_i[IQ_CONFIG]; // [R8]
      end
   end

   // runtime queue goes to the poller only
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         poller_cmd_valid_o <= 1'b0;
      end else if (!srst_n) begin
         poller_cmd_valid_o <= 1'b0;
      end else if (ce) begin
         poller_cmd_valid_o <= in_push_i[IQ_RUNTIME]; // [R9]
      end
   end

   // =========================================================
   // shared memory flags: poller posts stop/reset, player
   // consumes them at a window end; a new post wins over the clear
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_stop <= 1'b0;
      end else if (!srst_n) begin
         pend_stop <= 1'b0;
      end else if (ce) begin
         if (runtime_hit(in_push_i, in_cmd_i, cmd_stop_cycle)) begin
            pend_stop <= 1'b1; // [R12] [R4]
         end else if (window_end_i) begin
            pend_stop <= 1'b0;
         end
      end
   end

   // reset request flag, same set-over-clear priority
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_reset <= 1'b0;
      end else if (!srst_n) begin
         pend_reset <= 1'b0;
      end else if (ce) begin
         if (runtime_hit(in_push_i, in_cmd_i, cmd_reset_cycle)) begin
            pend_reset <= 1'b1; // [R12] [R4]
         end else if (window_end_i) begin
            pend_reset <= 1'b0;
         end
      end
   end

   // player sees a pending stop only at a window end
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         player_stop_o <= 1'b0;
      end else if (!srst_n) begin
         player_stop_o <= 1'b0;
      end else if (ce) begin
         player_stop_o <= window_end_i && pend_stop; // [R11]
      end
   end

   // player sees a pending reset only at a window end
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         player_reset_o <= 1'b0;
      end else if (!srst_n) begin
         player_reset_o <= 1'b0;
      end else if (ce) begin
         player_reset_o <= window_end_i && pend_reset; // [R11]
      end
   end

   // =========================================================
   // interrupt merge: any push on any host queue
   // outgoing queues grouped by owning processor; debug is shared
   assign player_push = (|out_push_i[OQ_APER_DIAG:OQ_PERIODIC_DATA])
                        || out_push_i[OQ_RESP_PLAYER]; // [R10]
   assign poller_push = out_push_i[OQ_RESP_POLLER]; // [R10]
   assign shared_push = out_push_i[OQ_DEBUG]; // [R10]
   assign irq_any     = player_push || poller_push || shared_push
                        || (|in_push_i); // [R13] [R15]

   // stretched pulse so the bridge edge detector sees each push;
   // pushes during a pulse extend it and raise no new edge
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_cnt <= 4'h0;
         irq_o   <= 1'b0;
      end else if (!srst_n) begin
         irq_cnt <= 4'h0;
         irq_o   <= 1'b0;
      end else if (ce) begin
         if (irq_any) begin
            irq_cnt <= IRQ_PULSE_CYCLES; // [R19]
            irq_o   <= 1'b1; // [R14]
         end else if (irq_cnt > 4'h1) begin
            irq_cnt <= irq_cnt - 4'h1;
         end else begin
            irq_cnt <= 4'h0;
            irq_o   <= 1'b0;
         end
      end
   end

   // =========================================================
   // oscillator DAC, held in reset until the system reset lifts
   fmnt_dac_arbiter u_dac (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i && srst_n),
      .ce_i     (ce),
      .dac      (dac_bus.arbiter)
   );

   // register DAC lines at the pins
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dac_sclk_o   <= 1'b0;
         dac_sync_n_o <= 1'b1;
         dac_din_o    <= 1'b0;
         dac_done_o   <= 1'b0;
      end else begin
         dac_sclk_o   <= dac_bus.sclk;
         dac_sync_n_o <= dac_bus.sync_n;
         dac_din_o    <= dac_bus.din;
         dac_done_o   <= dac_bus.done;
      end
   end
   // [R4] [R7] processors, their shared memory and the application
   // core bus live outside; the mailbox flags above stand in for the
   // shared memory words that this top must see
   // [R5] [R6] queue counts are fixed in the package: eight out, two
   // in, no remote queues and no timing network logic, so none of
   // them costs logic or a port here
endmodule

// *** hdl/fmnt_pkg.sv ***
// package of constants shared by the fieldbus master node top
package fmnt_pkg;
   // ========================================================
   // clocks
   localparam int CARRIER_CLK_MHZ = 125;
   localparam int SYS_CLK_MHZ     = 100;
   // fractional divider: 4 enables out of every 5 carrier cycles
   localparam logic [2:0] CLK_DIV_PERIOD = 3'h5;
   localparam logic [2:0] CLK_DIV_SKIP   = 3'h4;
   // ========================================================
   // reset synchroniser depth
   localparam int RST_SYNC_STAGES = 2;
   // ========================================================
   // message queues
   localparam int NUM_OUT_QUEUES    = 8;
   localparam int NUM_IN_QUEUES     = 2;
   localparam int NUM_REMOTE_QUEUES = 0;
   localparam int NUM_IRQ_SRC       = NUM_OUT_QUEUES + NUM_IN_QUEUES;
   // outgoing queue roles
   localparam int OQ_PERIODIC_DATA  = 0;
   localparam int OQ_APER_VARS      = 1;
   localparam int OQ_APER_MSGS      = 2;
   localparam int OQ_PER_DIAG       = 3;
   localparam int OQ_APER_DIAG      = 4;
   localparam int OQ_DEBUG          = 5;
   localparam int OQ_RESP_PLAYER    = 6;
   localparam int OQ_RESP_POLLER    = 7;
   // incoming queue routing
   localparam int IQ_CONFIG         = 0;
   localparam int IQ_RUNTIME        = 1;
   // ========================================================
   // host commands
   typedef enum logic [3:0] {
      cmd_set_hardware_config = 4'h1,
      cmd_set_variable_list   = 4'h2,
      cmd_load_cycle          = 4'h3,
      cmd_start_cycle         = 4'h4,
      cmd_stop_cycle          = 4'h5,
      cmd_reset_cycle         = 4'h6
   } fmnt_cmd_t;
   // ========================================================
   // host bridge regions
   localparam logic [2:0] BAR_LOCAL_BUS = 3'h0;
   localparam logic [2:0] BAR_BRIDGE    = 3'h4;
   // ========================================================
   // oscillator DAC
   localparam logic [15:0] DAC_DEFAULT_CODE = 16'h9999;
   localparam int          DAC_BITS         = 16;
   localparam logic [3:0]  DAC_SCLK_DIV     = 4'h4;
   // ========================================================
   // interrupt output pulse length in system cycles
   localparam logic [3:0]  IRQ_PULSE_CYCLES = 4'h4;
endpackage

// *** hdl/fmnt_dac_if.sv ***
// interface between the node top and the oscillator DAC arbiter
`timescale 1ns/1ps
interface fmnt_dac_if;
   logic sclk;
   logic sync_n;
   logic din;
   logic done;
   modport arbiter (output sclk, output sync_n, output din, output done);
   modport top     (input sclk, input sync_n, input din, input done);
endinterface

// *** hdl/fmnt_dac_arbiter.sv ***
// serial DAC arbiter: sends the fixed code once after reset
`timescale 1ns/1ps
module fmnt_dac_arbiter
   import fmnt_pkg::*;
(
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic arst_n_i,
   input  wire logic ce_i,
   // serial DAC
   fmnt_dac_if.arbiter dac
);
   typedef enum logic [1:0] {
      FMNT_DS_START = 2'b00,
      FMNT_DS_SHIFT = 2'b01,
      FMNT_DS_IDLE  = 2'b10
   } fmnt_dac_st_t;

   fmnt_dac_st_t st;
   logic [15:0]  shreg;
   logic [4:0]   bit_cnt;
   logic [3:0]   div_cnt;
   logic         phase;

   // =========================================================
   // serial clock divider, runs only on system enables
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_cnt <= 4'h0;
         phase   <= 1'b0;
      end else if (ce_i && st == FMNT_DS_SHIFT) begin
         if (div_cnt == DAC_SCLK_DIV - 4'h1) begin
            div_cnt <= 4'h0;
            phase   <= ~phase;
         end else begin
            div_cnt <= div_cnt + 4'h1;
         end
      end
   end

   // =========================================================
   // one shot transfer; idle afterwards keeps the VCXO voltage steady
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st       <= FMNT_DS_START;
         shreg    <= 16'h0000;
         bit_cnt  <= 5'h00;
         dac.sclk   <= 1'b0;
         dac.sync_n <= 1'b1;
         dac.din    <= 1'b0;
         dac.done   <= 1'b0;
      end else if (ce_i) begin
         case (st)
            FMNT_DS_START: begin
               shreg      <= {DAC_DEFAULT_CODE[14:0], 1'b0}; // [R17]
               dac.din    <= DAC_DEFAULT_CODE[15]; // [R17]
               bit_cnt    <= 5'(DAC_BITS);
               dac.sync_n <= 1'b0;
               st         <= FMNT_DS_SHIFT;
            end
            FMNT_DS_SHIFT: begin
               if (div_cnt == DAC_SCLK_DIV - 4'h1) begin
                  if (!phase) begin
                     // data has stood for half a bit; the receiver samples now
                     dac.sclk <= 1'b1;
                  end else begin
                     // next bit changes as sclk falls, never on its rise
                     dac.din  <= shreg[15];
                     shreg    <= {shreg[14:0], 1'b0};
                     dac.sclk <= 1'b0;
                     bit_cnt  <= bit_cnt - 5'h01;
                     if (bit_cnt == 5'h01) begin
                        dac.sync_n <= 1'b1;
                        dac.done   <= 1'b1;
                        st         <= FMNT_DS_IDLE; // [R18]
                     end
                  end
               end
            end
            FMNT_DS_IDLE: begin
               st <= FMNT_DS_IDLE;
            end
            default: begin
               st <= FMNT_DS_IDLE;
            end
         endcase
      end
   end
endmodule

// *** tb/fmnt_gateware_sva.sv ***
// assertion checker bound to the fieldbus master node top ports
`timescale 1ns/1ps
module fmnt_gateware_sva
   import fmnt_pkg::*;
(
   // clock and reset
   input wire logic                      mclk_i,
   input wire logic                      arst_n_i,
   // stimulus seen at the ports
   input wire logic                      host_req_i,
   input wire logic [2:0]                host_bar_i,
   input wire logic [NUM_OUT_QUEUES-1:0] out_push_i,
   input wire logic [NUM_IN_QUEUES-1:0]  in_push_i,
   input wire logic                      window_end_i,
   // design outputs
   input wire logic                      sys_ce_o,
   input wire logic                      sys_rst_n_o,
   input wire logic                      local_bus_sel_o,
   input wire logic                      bridge_reg_sel_o,
   input wire logic                      dma_port_used_o,
   input wire logic                      player_cmd_valid_o,
   input wire logic                      poller_cmd_valid_o,
   input wire logic                      player_stop_o,
   input wire logic                      player_reset_o,
   input wire logic                      irq_o,
   input wire logic                      dac_sclk_o,
   input wire logic                      dac_sync_n_o,
   input wire logic                      dac_done_o
);
   // ==========================================================
   // one domain, so clock and reset are given once
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);
   // interrupt stays up for the rest of its pulse
   sequence irq_hold_s;
      irq_o [*3];
   endsequence
   // four enabled cycles in a row, the most the divider allows
   sequence ce_run_s;
      sys_ce_o [*4];
   endsequence
   // ==========================================================
   // reset release must pass through the synchroniser
   rst_sync_a: assert property ($rose(sys_rst_n_o) |-> $past(arst_n_i, 2))
      else $error("system reset rose too early");
   ce_skip_a: assert property ((sys_rst_n_o throughout ce_run_s) |=> !sys_ce_o)
      else $error("enable high for five cycles");
   ce_gap_a: assert property ((sys_rst_n_o && !sys_ce_o) |=> sys_ce_o)
      else $error("enable low for two cycles");
   dma_unused_a: assert property (!dma_port_used_o)
      else $error("dma port in use");
   local_decode_a: assert property ($rose(local_bus_sel_o) |->
      $past(host_req_i) && $past(host_bar_i) == BAR_LOCAL_BUS)
      else $error("local bus selected without region 0 access");
   bridge_decode_a: assert property ($rose(bridge_reg_sel_o) |->
      $past(host_req_i) && $past(host_bar_i) == BAR_BRIDGE)
      else $error("bridge selected without region 4 access");
   player_route_a: assert property ($rose(player_cmd_valid_o) |-> $past(in_push_i[0]))
      else $error("player command without config push");
   poller_route_a: assert property ($rose(poller_cmd_valid_o) |-> $past(in_push_i[1]))
      else $error("poller command without runtime push");
   stop_cause_a: assert property (($rose(player_stop_o) || $rose(player_reset_o))
      |-> $past(window_end_i))
      else $error("stop or reset outside window end");
   push_irq_a: assert property ((sys_rst_n_o && (|out_push_i || |in_push_i))
      |-> ##[1:3] irq_o)
      else $error("queue push raised no interrupt");
   irq_width_a: assert property ($rose(irq_o) |=> irq_hold_s)
      else $error("interrupt pulse too short");
   irq_cause_a: assert property ($rose(irq_o) |-> $past(|out_push_i || |in_push_i))
      else $error("interrupt without a push");
   dac_idle_a: assert property (dac_done_o |=>
      dac_done_o && dac_sync_n_o && $stable(dac_sclk_o))
      else $error("dac active after its single write");
endmodule
bind fmnt_gateware_top fmnt_gateware_sva u_sva (
   .mclk_i(mclk_i), .arst_n_i(arst_n_i), .host_req_i(host_req_i),
   .host_bar_i(host_bar_i), .out_push_i(out_push_i), .in_push_i(in_push_i),
   .window_end_i(window_end_i), .sys_ce_o(sys_ce_o), .sys_rst_n_o(sys_rst_n_o),
   .local_bus_sel_o(local_bus_sel_o), .bridge_reg_sel_o(bridge_reg_sel_o),
   .dma_port_used_o(dma_port_used_o), .player_cmd_valid_o(player_cmd_valid_o),
   .poller_cmd_valid_o(poller_cmd_valid_o), .player_stop_o(player_stop_o),
   .player_reset_o(player_reset_o), .irq_o(irq_o), .dac_sclk_o(dac_sclk_o),
   .dac_sync_n_o(dac_sync_n_o), .dac_done_o(dac_done_o));

// *** tb/fmnt_far_side_model.sv ***
// far side model: bridge interrupt input and oscillator dac receiver
`timescale 1ns/1ps
module fmnt_far_side_model (
   // interrupt line into the bridge gpio
   input  wire logic        irq_i,
   // serial dac lines
   input  wire logic        dac_sclk_i,
   input  wire logic        dac_sync_n_i,
   input  wire logic        dac_din_i,
   // what the far side has seen
   output int               msi_count_o,
   output logic [15:0]      dac_word_o,
   output int               dac_bits_o
);
   // ==========================================================
   // only a rising edge makes a message interrupt, a held level does not
   initial msi_count_o = 0;
   always @(posedge irq_i) msi_count_o++;
   // ==========================================================
   // a frame opens with sync low; data is taken on sclk rise, msb first
   initial dac_bits_o = 0;
   initial dac_word_o = 16'h0000;
   always @(negedge dac_sync_n_i) dac_bits_o = 0;
   always @(posedge dac_sclk_i) begin
      if (dac_sync_n_i === 1'b0) begin
         dac_word_o = {dac_word_o[14:0], dac_din_i};
         dac_bits_o++;
      end
   end
endmodule

// *** tb/fmnt_gateware_top_bench.sv ***
// self-checking bench for the fieldbus master node top
`timescale 1ns/1ps
module fmnt_gateware_top_bench;
   import fmnt_pkg::*;
   // ==========================================================
   // stimulus vector: req, bar, out pushes, in pushes, cmd, window end
   logic        mclk_i;
   logic        arst_n_i;
   logic [18:0] stim;
   wire  logic  host_req_i, window_end_i;
   wire  logic [2:0] host_bar_i;
   wire  logic [7:0] out_push_i;
   wire  logic [1:0] in_push_i;
   wire  logic [3:0] in_cmd_i;
   logic        sys_ce_o, sys_rst_n_o, local_bus_sel_o, bridge_reg_sel_o, dma_port_used_o;
   logic        player_cmd_valid_o, poller_cmd_valid_o, player_stop_o, player_reset_o;
   logic        irq_o, dac_sclk_o, dac_sync_n_o, dac_din_o, dac_done_o;
   int          msi_count, dac_bits, num_errors, n_tests;
   logic [15:0] dac_word;
   assign {host_req_i, host_bar_i, out_push_i, in_push_i, in_cmd_i, window_end_i} = stim;
   // ==========================================================
   // 4 ns clock
   initial mclk_i = 1'b0;
   always #2 mclk_i = ~mclk_i;
   fmnt_gateware_top i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .host_req_i(host_req_i),
      .host_bar_i(host_bar_i), .out_push_i(out_push_i), .in_push_i(in_push_i),
      .in_cmd_i(in_cmd_i), .window_end_i(window_end_i), .sys_ce_o(sys_ce_o),
      .sys_rst_n_o(sys_rst_n_o), .local_bus_sel_o(local_bus_sel_o),
      .bridge_reg_sel_o(bridge_reg_sel_o), .dma_port_used_o(dma_port_used_o),
      .player_cmd_valid_o(player_cmd_valid_o), .poller_cmd_valid_o(poller_cmd_valid_o),
      .player_stop_o(player_stop_o), .player_reset_o(player_reset_o), .irq_o(irq_o),
      .dac_sclk_o(dac_sclk_o), .dac_sync_n_o(dac_sync_n_o), .dac_din_o(dac_din_o),
      .dac_done_o(dac_done_o));
   fmnt_far_side_model i_far (.irq_i(irq_o), .dac_sclk_i(dac_sclk_o),
      .dac_sync_n_i(dac_sync_n_o), .dac_din_i(dac_din_o), .msi_count_o(msi_count),
      .dac_word_o(dac_word), .dac_bits_o(dac_bits));
   // ==========================================================
   // shared helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // held for two edges so one lands on an enabled cycle whatever the phase
   task automatic act(input logic [18:0] s, output logic [6:0] seen);
      seen = 7'h00;
      @(posedge mclk_i);
      stim <= s;
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk_i);
         if (i == 1)
            stim <= 19'h00000;
         seen |= {irq_o, player_reset_o, player_stop_o, poller_cmd_valid_o,
                  player_cmd_valid_o, bridge_reg_sel_o, local_bus_sel_o};
      end
      repeat (12) @(posedge mclk_i);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // bounded wait for the dac's single frame to finish
   task automatic wait_dac;
      for (int i = 0; i < 3000 && dac_done_o !== 1'b1; i++)
         @(posedge mclk_i);
      chk({15'h0000, dac_done_o}, 16'h0001);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      int n;
      n = 0;
      for (int i = 0; i < 20 && sys_rst_n_o !== 1'b1; i++)
         @(posedge mclk_i);
      chk({15'h0000, sys_rst_n_o}, 16'h0001);
      chk({15'h0000, dma_port_used_o}, 16'h0000);
      repeat (50) begin
         @(posedge mclk_i);
         n += (sys_ce_o === 1'b1);
      end
      chk(16'(n), 16'h0028);
      $display("test reset done");
   endtask
   task automatic t_bar;
      logic [6:0] seen;
      logic [2:0] bars [3] = '{3'h0, 3'h4, 3'h2};
      logic [6:0] exp [3] = '{7'h01, 7'h02, 7'h00};
      for (int k = 0; k < 3; k++) begin
         act({1'b1, bars[k], 15'h0000}, seen);
         chk({9'h000, seen}, {9'h000, exp[k]});
      end
      $display("test region decode done");
   endtask
   task automatic t_route;
      logic [6:0] seen;
      for (int c = 1; c <= 4; c++) begin
         act({12'h000, 2'b01, 4'(c), 1'b0}, seen);
         chk({9'h000, seen}, 16'h0044);
      end
      act({12'h000, 2'b10, 4'h0, 1'b0}, seen);
      chk({9'h000, seen}, 16'h0048);
      $display("test routing done");
   endtask
   task automatic t_irq;
      logic [6:0]  seen;
      logic [18:0] s;
      int          m;
      for (int q = 0; q < NUM_IRQ_SRC; q++) begin
         s = 19'h00000;
         s[q < 8 ? 7 + q : q - 3] = 1'b1;
         m = msi_count;
         act(s, seen);
         chk({15'h0000, seen[6]}, 16'h0001);
         chk(16'(msi_count - m), 16'h0001);
      end
      $display("test interrupts done");
   endtask
   task automatic t_stop;
      logic [6:0] seen;
      act({12'h000, 2'b10, 4'h5, 1'b0}, seen);
      chk({9'h000, seen}, 16'h0048);
      act({18'h00000, 1'b1}, seen);
      chk({9'h000, seen}, 16'h0010);
      act({12'h000, 2'b10, 4'h6, 1'b0}, seen);
      act({18'h00000, 1'b1}, seen);
      chk({9'h000, seen}, 16'h0020);
      act({18'h00000, 1'b1}, seen);
      chk({9'h000, seen}, 16'h0000);
      // post and window end together: the post must outlive the clear
      act({12'h000, 2'b10, 4'h5, 1'b1}, seen);
      chk({9'h000, seen & 7'h6F}, 16'h0048);
      act({18'h00000, 1'b1}, seen);
      chk({9'h000, seen}, 16'h0010);
      $display("test stop and reset done");
   endtask
   task automatic t_dac;
      wait_dac();
      chk(dac_word, DAC_DEFAULT_CODE);
      chk(16'(dac_bits), 16'(DAC_BITS));
      @(posedge mclk_i);
      arst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      chk({15'h0000, dac_done_o}, 16'h0000);
      arst_n_i <= 1'b1;
      wait_dac();
      repeat (200) @(posedge mclk_i);
      chk(dac_word, DAC_DEFAULT_CODE);
      chk(16'(dac_bits), 16'(DAC_BITS));
      $display("test dac done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      num_errors = 0;
      n_tests = 0;
      stim = 19'h00000;
      arst_n_i = 1'b0;
      repeat (10) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_bar();
      t_route();
      t_irq();
      t_stop();
      t_dac();
      tally_and_finish();
   end
   initial begin
      #(4 * 40000);
      num_errors++;
      tally_and_finish();
   end
endmodule
